// *** verilog/mrs_map.svh ***
// Register offsets, opcode patterns, field positions and reset values
// for the multiply / rotate / set instruction unit.
// Assumes it is included by the unit's design file and its self-checking bench only.
//
// Notes on behaviour
// (RULE_01) Literal multiply: unsigned W times literal, W kept
// (RULE_02) Product high byte upper, low byte lower
// (RULE_03) Multiplies never touch any status flag
// (RULE_04) Literal multiply opcode upper byte 0000 1101
// (RULE_05) Literal multiply finishes in one cycle
// (RULE_06) Register multiply: W times file, sources kept
// (RULE_07) Register multiply opcode 0000 001, bank, address
// (RULE_08) Register multiply finishes in one cycle
// (RULE_09) Rotate opcode 0100 00, destination, bank, address
// (RULE_10) Rotate updates only negative and zero flags
// (RULE_11) Set opcode 0110 100 writes all ones
// (RULE_12) Rotate right, bit 0 to 7, destination bit
// (RULE_13) Bank bit 0 access bank, 1 uses bank select
`ifndef MRS_MAP_SVH
`define MRS_MAP_SVH

// Register byte offsets
`define MRS_OFS_INSTR     12'h000
`define MRS_OFS_WORK      12'h004
`define MRS_OFS_BANK      12'h008
`define MRS_OFS_STATUS    12'h00C
`define MRS_OFS_PRODUCT   12'h010
`define MRS_OFS_MEM_ADDR  12'h014
`define MRS_OFS_MEM_DATA  12'h018
`define MRS_OFS_EXEC_STAT 12'h01C

// Opcode patterns and their fields
`define MRS_PAT_MULLIT    8'h0D
`define MRS_PAT_MULREG    7'h01
`define MRS_PAT_ROTATE    6'h10
`define MRS_PAT_SETONES   7'h34
`define MRS_BIT_BANK      8
`define MRS_BIT_DEST      9
`define MRS_ALL_ONES      8'hFF

// Status bit positions and reset values
`define MRS_ST_ZERO       0
`define MRS_ST_NEG        1
`define MRS_ES_ILLEGAL    0
`define MRS_RST_BYTE      8'h00
`define MRS_RST_WORD      16'h0000

// AXI responses
`define MRS_RESP_OKAY     2'h0
`define MRS_RESP_SLVERR   2'h2

`endif

// *** verilog/mrs_pkg.sv ***
// Types shared by the multiply / rotate / set instruction unit.
// Assumes nothing of its surroundings.
`default_nettype none
package mrs_pkg;
	// Execution sequencer, one-hot
	typedef enum logic [1:0] {
		MRS_IDLE = 2'h1,
		MRS_EXEC = 2'h2
	} mrs_state_t;
	// Decoded instruction class
	typedef enum logic [2:0] {
		MRS_OP_NONE    = 3'h0,
		MRS_OP_MULLIT  = 3'h1,
		MRS_OP_MULREG  = 3'h2,
		MRS_OP_ROTATE  = 3'h3,
		MRS_OP_SETONES = 3'h4
	} mrs_op_t;
endpackage
`default_nettype wire

// *** verilog/mrs_core.sv ***
// Multiply / rotate / set instruction unit with its own working register,
// bank select, status, product pair and file-register storage.
// Assumes an AXI4-Lite master on the same clock; one write, one read.
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`include "mrs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module mrs_core #(
	parameter int ADDR_W = 9               // File storage address width
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [11:0] awaddr,
	input  wire logic [2:0]  awprot,
	input  wire logic        wvalid,
	output logic             wready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	output logic             bvalid,
	input  wire logic        bready,
	output logic [1:0]       bresp,
	input  wire logic        arvalid,
	output logic             arready,
	input  wire logic [11:0] araddr,
	input  wire logic [2:0]  arprot,
	output logic             rvalid,
	input  wire logic        rready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp
);
	localparam int DEPTH = 2 ** ADDR_W;    // Bytes of file storage

	////////////////////////////////////////////////////////////////////
	// Functions

	// Merge write data into an old word under byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return (old_v & ~m) | (new_v & m);
	endfunction

	// Instruction class from the upper opcode bits
	function automatic mrs_pkg::mrs_op_t decode(input logic [15:0] iw);
		if (iw[15:8] == `MRS_PAT_MULLIT)  // RULE_04
			return mrs_pkg::MRS_OP_MULLIT;
		else if (iw[15:9] == `MRS_PAT_MULREG)  // RULE_07
			return mrs_pkg::MRS_OP_MULREG;
		else if (iw[15:10] == `MRS_PAT_ROTATE)  // RULE_09
			return mrs_pkg::MRS_OP_ROTATE;
		else if (iw[15:9] == `MRS_PAT_SETONES)  // RULE_11
			return mrs_pkg::MRS_OP_SETONES;
		else
			return mrs_pkg::MRS_OP_NONE;
	endfunction

	// Storage index of a file operand
	function automatic logic [ADDR_W-1:0] eff_addr(input logic a,
		input logic [3:0] bank, input logic [7:0] f);
		logic [11:0] full;
		full = a ? {bank, f} : {4'h0, f};  // RULE_13
		return full[ADDR_W-1:0];
	endfunction

	////////////////////////////////////////////////////////////////////
	// State

	logic             aw_held_reg, aw_held_next;   // Write address taken
	logic [11:0]      aw_addr_reg, aw_addr_next;
	logic             w_held_reg, w_held_next;     // Write data taken
	logic [31:0]      w_data_reg, w_data_next;
	logic [3:0]       w_strb_reg, w_strb_next;
	logic             awready_reg, awready_next;
	logic             wready_reg, wready_next;
	logic             bvalid_reg, bvalid_next;
	logic [1:0]       bresp_reg, bresp_next;
	logic             arready_reg, arready_next;
	logic             rvalid_reg, rvalid_next;
	logic [31:0]      rdata_reg, rdata_next;
	logic [1:0]       rresp_reg, rresp_next;

	mrs_pkg::mrs_state_t state_reg, state_next; // Sequencer
	logic [15:0]      instr_reg, instr_next;       // Pending instruction
	logic [7:0]       work_reg, work_next;         // Working register
	logic [3:0]       bank_reg, bank_next;         // Bank select
	logic [1:0]       status_reg, status_next;     // Negative, zero
	logic [7:0]       product_high_reg, product_high_next;
	logic [7:0]       product_low_reg, product_low_next;
	logic [ADDR_W-1:0] maddr_reg, maddr_next;      // Storage window
	logic             illegal_reg, illegal_next;   // Unknown opcode seen
	logic [7:0]       mem_reg [DEPTH];             // File registers
	logic [7:0]       mem_next [DEPTH];

	logic             wr_fire;      // Register write happens now
	logic             wr_ok;        // Address is mapped
	logic             exec_en;      // Instruction cycle
	mrs_pkg::mrs_op_t exec_op;      // Class of pending instruction
	logic [ADDR_W-1:0] f_idx;       // File operand index
	logic [7:0]       f_val;        // File operand value
	logic [7:0]       rot_res;      // Rotated operand
	logic [15:0]      prod_lit;     // W times literal
	logic [15:0]      prod_reg;     // W times file operand

	assign exec_en  = (state_reg == mrs_pkg::MRS_EXEC);
	assign exec_op  = decode(instr_reg);
	assign f_idx    = eff_addr(instr_reg[`MRS_BIT_BANK], bank_reg,
		instr_reg[7:0]);
	assign f_val    = mem_reg[f_idx];
	assign rot_res  = {f_val[0], f_val[7:1]};  // RULE_12
	assign prod_lit = 16'(work_reg * instr_reg[7:0]);  // RULE_01
	assign prod_reg = 16'(work_reg * f_val);  // RULE_06
	// No write lands while an instruction executes
	assign wr_fire  = aw_held_reg && w_held_reg && !bvalid_reg &&
		!exec_en;
	assign wr_ok    = (aw_addr_reg[11:2] <= `MRS_OFS_EXEC_STAT >> 2);

	////////////////////////////////////////////////////////////////////
	// Bus handshakes, next values
	always_comb begin
		aw_held_next = aw_held_reg;
		aw_addr_next = aw_addr_reg;
		w_held_next  = w_held_reg;
		w_data_next  = w_data_reg;
		w_strb_next  = w_strb_reg;
		bvalid_next  = bvalid_reg;
		bresp_next   = bresp_reg;
		rvalid_next  = rvalid_reg;
		rdata_next   = rdata_reg;
		rresp_next   = rresp_reg;
		// Address and data taken in either order
		if (awvalid && awready_reg) begin
			aw_held_next = 1'b1;
			aw_addr_next = awaddr;
		end
		if (wvalid && wready_reg) begin
			w_held_next = 1'b1;
			w_data_next = wdata;
			w_strb_next = wstrb;
		end
		// Response after both halves
		if (bvalid_reg && bready)
			bvalid_next = 1'b0;
		if (wr_fire) begin
			aw_held_next = 1'b0;
			w_held_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = wr_ok ? `MRS_RESP_OKAY : `MRS_RESP_SLVERR;
		end
		// Read answered one cycle after the address
		if (rvalid_reg && rready)
			rvalid_next = 1'b0;
		if (arvalid && arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next  = `MRS_RESP_OKAY;
			rdata_next  = 32'h0;
			if (araddr[11:2] == `MRS_OFS_INSTR >> 2)
				rdata_next[15:0] = instr_reg;
			else if (araddr[11:2] == `MRS_OFS_WORK >> 2)
				rdata_next[7:0] = work_reg;
			else if (araddr[11:2] == `MRS_OFS_BANK >> 2)
				rdata_next[3:0] = bank_reg;
			else if (araddr[11:2] == `MRS_OFS_STATUS >> 2)
				rdata_next[1:0] = status_reg;
			else if (araddr[11:2] == `MRS_OFS_PRODUCT >> 2)
				rdata_next[15:0] = {product_high_reg, product_low_reg};
			else if (araddr[11:2] == `MRS_OFS_MEM_ADDR >> 2)
				rdata_next[ADDR_W-1:0] = maddr_reg;
			else if (araddr[11:2] == `MRS_OFS_MEM_DATA >> 2)
				rdata_next[7:0] = mem_reg[maddr_reg];
			else if (araddr[11:2] == `MRS_OFS_EXEC_STAT >> 2)
				rdata_next[`MRS_ES_ILLEGAL] = illegal_reg;
			else
				rresp_next = `MRS_RESP_SLVERR;
		end
		// Ready only while the slot is free
		awready_next = !aw_held_next;
		wready_next  = !w_held_next;
		arready_next = !rvalid_next;
	end

	// Bus handshakes, registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			aw_addr_reg <= 12'h0;
			w_held_reg  <= 1'b0;
			w_data_reg  <= 32'h0;
			w_strb_reg  <= 4'h0;
			awready_reg <= 1'b0;
			wready_reg  <= 1'b0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= `MRS_RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= 32'h0;
			rresp_reg   <= `MRS_RESP_OKAY;
		end else begin
			aw_held_reg <= aw_held_next;
			aw_addr_reg <= aw_addr_next;
			w_held_reg  <= w_held_next;
			w_data_reg  <= w_data_next;
			w_strb_reg  <= w_strb_next;
			awready_reg <= awready_next;
			wready_reg  <= wready_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg  <= rvalid_next;
			rdata_reg   <= rdata_next;
			rresp_reg   <= rresp_next;
		end
	end

	assign awready = awready_reg;
	assign wready  = wready_reg;
	assign bvalid  = bvalid_reg;
	assign bresp   = bresp_reg;
	assign arready = arready_reg;
	assign rvalid  = rvalid_reg;
	assign rdata   = rdata_reg;
	assign rresp   = rresp_reg;

	////////////////////////////////////////////////////////////////////
	// Core registers and execution, next values
	always_comb begin
		logic [31:0] mw;
		mw                = 32'h0;
		state_next        = state_reg;
		instr_next        = instr_reg;
		work_next         = work_reg;
		bank_next         = bank_reg;
		status_next       = status_reg;
		product_high_next = product_high_reg;
		product_low_next  = product_low_reg;
		maddr_next        = maddr_reg;
		illegal_next      = illegal_reg;
		mem_next          = mem_reg;
		// Software writes, idle only
		if (wr_fire) begin
			if (aw_addr_reg[11:2] == `MRS_OFS_INSTR >> 2) begin
				mw = merge({16'h0, instr_reg}, w_data_reg, w_strb_reg);
				instr_next = mw[15:0];
				state_next = mrs_pkg::MRS_EXEC;
			end else if (aw_addr_reg[11:2] == `MRS_OFS_WORK >> 2) begin
				mw = merge({24'h0, work_reg}, w_data_reg, w_strb_reg);
				work_next = mw[7:0];
			end else if (aw_addr_reg[11:2] == `MRS_OFS_BANK >> 2) begin
				mw = merge({28'h0, bank_reg}, w_data_reg, w_strb_reg);
				bank_next = mw[3:0];
			end else if (aw_addr_reg[11:2] == `MRS_OFS_STATUS >> 2) begin
				mw = merge({30'h0, status_reg}, w_data_reg, w_strb_reg);
				status_next = mw[1:0];
			end else if (aw_addr_reg[11:2] == `MRS_OFS_MEM_ADDR >> 2) begin
				mw = merge(32'(maddr_reg), w_data_reg, w_strb_reg);
				maddr_next = mw[ADDR_W-1:0];
			end else if (aw_addr_reg[11:2] == `MRS_OFS_MEM_DATA >> 2) begin
				mw = merge({24'h0, mem_reg[maddr_reg]}, w_data_reg,
					w_strb_reg);
				mem_next[maddr_reg] = mw[7:0];
			end else if (aw_addr_reg[11:2] == `MRS_OFS_EXEC_STAT >> 2) begin
				// Write one to clear
				if (w_strb_reg[0] && w_data_reg[`MRS_ES_ILLEGAL])
					illegal_next = 1'b0;
			end
		end
		// One instruction cycle: decode, read, compute, write
		case (state_reg)
			mrs_pkg::MRS_EXEC: begin
				state_next = mrs_pkg::MRS_IDLE;  // RULE_05 RULE_08
				case (exec_op)
					mrs_pkg::MRS_OP_MULLIT: begin
						// Flags and W left alone
						product_high_next = prod_lit[15:8];  // RULE_02
						product_low_next  = prod_lit[7:0];  // RULE_02
					end
					mrs_pkg::MRS_OP_MULREG: begin
						product_high_next = prod_reg[15:8];  // RULE_06
						product_low_next  = prod_reg[7:0];  // RULE_03
					end
					mrs_pkg::MRS_OP_ROTATE: begin
						if (instr_reg[`MRS_BIT_DEST])  // RULE_12
							mem_next[f_idx] = rot_res;
						else
							work_next = rot_res;
						status_next[`MRS_ST_NEG]  = rot_res[7];  // RULE_10
						status_next[`MRS_ST_ZERO] = (rot_res == 8'h0);
					end
					mrs_pkg::MRS_OP_SETONES:
						mem_next[f_idx] = `MRS_ALL_ONES;  // RULE_11
					default:
						illegal_next = 1'b1;
				endcase
			end
			default: ;
		endcase
	end

	// Core registers, registered; storage keeps no reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg        <= mrs_pkg::MRS_IDLE;
			instr_reg        <= `MRS_RST_WORD;
			work_reg         <= `MRS_RST_BYTE;
			bank_reg         <= 4'h0;
			status_reg       <= 2'h0;
			product_high_reg <= `MRS_RST_BYTE;
			product_low_reg  <= `MRS_RST_BYTE;
			maddr_reg        <= '0;
			illegal_reg      <= 1'b0;
		end else begin
			state_reg        <= state_next;
			instr_reg        <= instr_next;
			work_reg         <= work_next;
			bank_reg         <= bank_next;
			status_reg       <= status_next;
			product_high_reg <= product_high_next;
			product_low_reg  <= product_low_next;
			maddr_reg        <= maddr_next;
			illegal_reg      <= illegal_next;
		end
		mem_reg <= mem_next;
	end

	////////////////////////////////////////////////////////////////////
	// Assertions
	sequence s_instr_write;
		wr_fire && (aw_addr_reg[11:2] == `MRS_OFS_INSTR >> 2);
	endsequence
	sequence s_exec_then_idle;
		exec_en ##1 !exec_en;
	endsequence
	property p_one_cycle;
		@(posedge aclk) disable iff (!aresetn)
		s_instr_write |=> s_exec_then_idle;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("exec len"); // RULE_05
	property p_mullit;
		@(posedge aclk) disable iff (!aresetn)
		exec_en && exec_op == mrs_pkg::MRS_OP_MULLIT |=>
		{product_high_reg, product_low_reg} ==
		16'($past(work_reg) * $past(instr_reg[7:0])) && $stable(work_reg);
	endproperty
	a_mullit: assert property (p_mullit) else $error("lit product"); // RULE_01
	property p_mulreg;
		@(posedge aclk) disable iff (!aresetn)
		exec_en && exec_op == mrs_pkg::MRS_OP_MULREG |=>
		{product_high_reg, product_low_reg} ==
		16'($past(work_reg) * $past(f_val)) &&
		mem_reg[$past(f_idx)] == $past(f_val) && $stable(work_reg);
	endproperty
	a_mulreg: assert property (p_mulreg) else $error("reg product"); // RULE_06
	property p_mul_flags;
		@(posedge aclk) disable iff (!aresetn)
		exec_en && (exec_op == mrs_pkg::MRS_OP_MULLIT ||
		exec_op == mrs_pkg::MRS_OP_MULREG) |=> $stable(status_reg);
	endproperty
	a_mul_flags: assert property (p_mul_flags) else $error("flags"); // RULE_03
	property p_decode;
		@(posedge aclk) disable iff (!aresetn)
		// Raw opcode bits, not the decode function, pick the product
		exec_en && instr_reg[15:8] == `MRS_PAT_MULLIT |=>
		$stable(illegal_reg) && {product_high_reg, product_low_reg} ==
		16'($past(work_reg) * $past(instr_reg[7:0]));
	endproperty
	a_decode: assert property (p_decode) else $error("decode"); // RULE_04
	property p_rot_flags;
		@(posedge aclk) disable iff (!aresetn)
		exec_en && exec_op == mrs_pkg::MRS_OP_ROTATE |=>
		status_reg[`MRS_ST_NEG] == $past(f_val[0]) &&
		status_reg[`MRS_ST_ZERO] == ($past(f_val) == 8'h0);
	endproperty
	a_rot_flags: assert property (p_rot_flags) else $error("rot flags"); // RULE_10
	property p_rot_dest;
		@(posedge aclk) disable iff (!aresetn)
		exec_en && exec_op == mrs_pkg::MRS_OP_ROTATE &&
		!instr_reg[`MRS_BIT_DEST] |=>
		work_reg == {$past(f_val[0]), $past(f_val[7:1])};
	endproperty
	a_rot_dest: assert property (p_rot_dest) else $error("rot dest"); // RULE_12
	property p_setones;
		@(posedge aclk) disable iff (!aresetn)
		exec_en && exec_op == mrs_pkg::MRS_OP_SETONES |=>
		mem_reg[$past(f_idx)] == `MRS_ALL_ONES;
	endproperty
	a_setones: assert property (p_setones) else $error("set ones"); // RULE_11
	property p_bank;
		@(posedge aclk) disable iff (!aresetn)
		!instr_reg[`MRS_BIT_BANK] |-> f_idx == ADDR_W'(instr_reg[7:0]);
	endproperty
	a_bank: assert property (p_bank) else $error("access bank"); // RULE_13
endmodule
`default_nettype wire

// *** verification/tb_top.sv ***
// Self-checking bench for the multiply / rotate / set instruction unit.
// Assumes the unit's AXI4-Lite slave port and its register map header.
`include "mrs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
////////////////////////////////////////////////////////////////////////////
logic        aclk;      // Core clock, 100 ns period
logic        aresetn;   // Synchronous reset, active low
logic        awvalid;   // Write address channel
logic        awready;
logic [11:0] awaddr;
logic        wvalid;    // Write data channel
logic        wready;
logic [31:0] wdata;
logic        bvalid;    // Write response channel
logic        bready;
logic [1:0]  bresp;
logic        arvalid;   // Read address channel
logic        arready;
logic [11:0] araddr;
logic        rvalid;    // Read data channel
logic        rready;
logic [31:0] rdata;
logic [1:0]  rresp;
int          error_cnt; // Mismatches seen
int          n_checks;  // Comparisons made
int          cyc = 0;   // Watchdog cycle count
logic [31:0] v;         // Scratch read value
logic [7:0]  lw [3];    // Literal multiply: working values
logic [7:0]  lk [3];    // Literal multiply: literals
logic [15:0] lp [3];    // Literal multiply: expected products

mrs_core #(
	.ADDR_W(9)
) u_mrs_core (
	.aclk   (aclk),
	.aresetn(aresetn),
	.awvalid(awvalid),
	.awready(awready),
	.awaddr (awaddr),
	.awprot (3'h0),
	.wvalid (wvalid),
	.wready (wready),
	.wdata  (wdata),
	.wstrb  (4'hF),
	.bvalid (bvalid),
	.bready (bready),
	.bresp  (bresp),
	.arvalid(arvalid),
	.arready(arready),
	.araddr (araddr),
	.arprot (3'h0),
	.rvalid (rvalid),
	.rready (rready),
	.rdata  (rdata),
	.rresp  (rresp)
);

////////////////////////////////////////////////////////////////////////////
// Clock and watchdog; a hang ends in the same closing report
initial aclk = 1'b0;
always #50 aclk = ~aclk;

always @(posedge aclk) begin
	cyc <= cyc + 1;
	if (cyc == 6000) begin
		error_cnt = error_cnt + 1;
		close_out();
	end
end

////////////////////////////////////////////////////////////////////////////
// Comparison and reporting
task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
	n_checks = n_checks + 1;
	if (g !== e) begin
		$display("[FAIL] %s expected %h seen %h", n, e, g);
		error_cnt = error_cnt + 1;
	end
endtask

task automatic tdone(input string n);
	$display("test %s done, mismatches so far %0d", n, error_cnt);
endtask

task automatic close_out();
	$display("checks %0d mismatches %0d", n_checks, error_cnt);
	if (error_cnt == 0 && n_checks > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask

////////////////////////////////////////////////////////////////////////////
// Bus tasks: entered just after a rising edge, leave just after one
task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] er);
	logic aw_ok;
	logic w_ok;
	aw_ok = 1'b0;
	w_ok = 1'b0;
	awvalid <= 1'b1;
	awaddr <= a;
	wvalid <= 1'b1;
	wdata <= d;
	bready <= 1'b1;
	forever begin
		@(posedge aclk);
		// Address and data may be taken in either order
		if (!aw_ok && awready) begin
			aw_ok = 1'b1;
			awvalid <= 1'b0;
		end
		if (!w_ok && wready) begin
			w_ok = 1'b1;
			wvalid <= 1'b0;
		end
		// Ready stays high, so a following call assigns it once only
		if (bvalid) begin
			chk("bresp", {30'h0, er}, {30'h0, bresp});
			break;
		end
	end
endtask

task automatic rd(input logic [11:0] a, output logic [31:0] d,
		input logic [1:0] er);
	logic ar_ok;
	ar_ok = 1'b0;
	arvalid <= 1'b1;
	araddr <= a;
	rready <= 1'b1;
	forever begin
		@(posedge aclk);
		// Answer only counts once the address was taken
		if (ar_ok && rvalid) begin
			d = rdata;
			chk("rresp", {30'h0, er}, {30'h0, rresp});
			break;
		end
		if (!ar_ok && arready) begin
			ar_ok = 1'b1;
			arvalid <= 1'b0;
		end
	end
endtask

task automatic rchk(input string n, input logic [11:0] a,
		input logic [31:0] e);
	logic [31:0] g;
	rd(a, g, `MRS_RESP_OKAY);
	chk(n, e, g);
endtask

task automatic wok(input logic [11:0] a, input logic [31:0] d);
	wr(a, d, `MRS_RESP_OKAY);
endtask

// Issue one instruction; results settle one cycle after the response
task automatic exec(input logic [15:0] ins);
	wok(`MRS_OFS_INSTR, {16'h0000, ins});
	@(posedge aclk);
endtask

// Load one storage byte through the window
task automatic poke(input logic [8:0] idx, input logic [7:0] b);
	wok(`MRS_OFS_MEM_ADDR, {23'h0, idx});
	wok(`MRS_OFS_MEM_DATA, {24'h0, b});
endtask

task automatic peek(input string n, input logic [8:0] idx,
		input logic [7:0] e);
	wok(`MRS_OFS_MEM_ADDR, {23'h0, idx});
	rchk(n, `MRS_OFS_MEM_DATA, {24'h0, e});
endtask

////////////////////////////////////////////////////////////////////////////
// Main sequence
initial begin
	{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
	awaddr = 12'h000;
	araddr = 12'h000;
	wdata = 32'h0000_0000;
	aresetn = 1'b0;
	error_cnt = 0;
	n_checks = 0;
	lw = '{8'hE2, 8'hFF, 8'h00};
	lk = '{8'hC4, 8'hFF, 8'h37};
	lp = '{16'hAD08, 16'hFE01, 16'h0000};
	repeat (12) @(posedge aclk);
	aresetn <= 1'b1;
	repeat (2) @(posedge aclk);
	rchk("work reset", `MRS_OFS_WORK, 32'h0);
	rchk("product reset", `MRS_OFS_PRODUCT, 32'h0);
	tdone("reset");
	// Literal multiply, incl. full-scale and zero product
	for (int i = 0; i < 3; i++) begin
		wok(`MRS_OFS_WORK, {24'h0, lw[i]});
		wok(`MRS_OFS_STATUS, 32'h2);
		exec({8'h0D, lk[i]});
		rchk("mul lit prod", `MRS_OFS_PRODUCT, {16'h0, lp[i]});
		rchk("mul lit work", `MRS_OFS_WORK, {24'h0, lw[i]});
		rchk("mul lit status", `MRS_OFS_STATUS, 32'h2);
	end
	tdone("multiply literal");
	// Register multiply through bank select and through access bank
	wok(`MRS_OFS_BANK, 32'h1);
	poke(9'h135, 8'hB5);
	poke(9'h035, 8'h03);
	wok(`MRS_OFS_WORK, 32'hC4);
	wok(`MRS_OFS_STATUS, 32'h1);
	exec(16'h0335);
	rchk("mul reg product", `MRS_OFS_PRODUCT, 32'h8A94);
	rchk("mul reg work", `MRS_OFS_WORK, 32'hC4);
	peek("mul reg source", 9'h135, 8'hB5);
	rchk("mul reg status", `MRS_OFS_STATUS, 32'h1);
	exec(16'h0235);
	rchk("mul reg access bank", `MRS_OFS_PRODUCT, 32'h024C);
	tdone("multiply register");
	// Rotate right without carry, both destinations and flag cases
	poke(9'h040, 8'hD7);
	poke(9'h041, 8'h00);
	poke(9'h142, 8'h01);
	exec(16'h4240);
	peek("rot to file", 9'h040, 8'hEB);
	rchk("rot neg flag", `MRS_OFS_STATUS, 32'h2);
	exec(16'h4040);
	rchk("rot to work", `MRS_OFS_WORK, 32'hF5);
	peek("rot file kept", 9'h040, 8'hEB);
	exec(16'h4241);
	peek("rot zero value", 9'h041, 8'h00);
	rchk("rot zero flag", `MRS_OFS_STATUS, 32'h1);
	exec(16'h4342);
	peek("rot bank wrap", 9'h142, 8'h80);
	rchk("rot flags", `MRS_OFS_STATUS, 32'h2);
	rchk("rot product kept", `MRS_OFS_PRODUCT, 32'h024C);
	tdone("rotate");
	// Set all ones, banked and access bank
	poke(9'h150, 8'h5A);
	poke(9'h051, 8'h00);
	poke(9'h050, 8'h00);
	exec(16'h6950);
	exec(16'h6851);
	peek("set banked", 9'h150, 8'hFF);
	peek("set access", 9'h051, 8'hFF);
	peek("set neighbour", 9'h050, 8'h00);
	tdone("set all ones");
	// Unmapped places and an unknown opcode
	wr(12'h020, 32'hFFFF_FFFF, `MRS_RESP_SLVERR);
	rd(12'h024, v, `MRS_RESP_SLVERR);
	exec(16'hFFFF);
	rchk("illegal flag", `MRS_OFS_EXEC_STAT, 32'h1);
	rchk("illegal product", `MRS_OFS_PRODUCT, 32'h024C);
	wok(`MRS_OFS_EXEC_STAT, 32'h1);
	rchk("illegal cleared", `MRS_OFS_EXEC_STAT, 32'h0);
	tdone("refusals");
	close_out();
end

endmodule
`default_nettype wire
